// ---- inc/uart_pkg.sv ----
// Constants, types and register map of the serial port.
// Assumes a single 25 MHz system clock and an 8-bit register port.
package uart_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_POWER = 8'h87;
    localparam logic [7:0] ADDR_CONTROL = 8'h98;
    localparam logic [7:0] ADDR_DATA = 8'h99;
    localparam logic [7:0] ADDR_BAUD_SEL = 8'hc0;
    localparam logic [7:0] ADDR_T1_RELOAD = 8'hc1;
    localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'hc2;
    localparam logic [7:0] ADDR_T2_RELOAD_HI = 8'hc3;

    // Control register fields
    localparam int CTL_FMT_HI = 7;
    localparam int CTL_FMT_LO = 6;
    localparam int CTL_GATE = 5;
    localparam int CTL_REN = 4;
    localparam int CTL_TB8 = 3;
    localparam int CTL_RB8 = 2;
    localparam int CTL_TI = 1;
    localparam int CTL_RI = 0;

    // Power control and baud select fields
    localparam int PWR_DOUBLER = 7;
    localparam int SEL_T1_UNDIV = 0;
    localparam int SEL_T2_UNDIV = 1;
    localparam int SEL_T2_TX = 4;
    localparam int SEL_T2_RX = 5;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] BAUD_SEL_RESET = 8'h00;
    localparam logic [7:0] T1_RELOAD_RESET = 8'h00;
    localparam logic [15:0] T2_RELOAD_RESET = 16'h0000;
    localparam logic [10:0] TX_IDLE_LINE = 11'h7ff;

    // Timing counts
    localparam logic [3:0] PRESCALE_LAST = 4'hb;
    localparam logic [2:0] SYNC_HALF_SLOW_LAST = 3'h5;
    localparam logic [2:0] SYNC_HALF_FAST_LAST = 3'h1;
    localparam logic [1:0] FIXED_SLOW_LAST = 2'h3;
    localparam logic [1:0] FIXED_FAST_LAST = 2'h1;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_MID = 4'h7;
    localparam logic [7:0] T1_TOP = 8'hff;
    localparam logic [15:0] T2_TOP = 16'hffff;

    typedef enum logic [1:0] {FMT_SYNC, FMT_ASYNC10, FMT_FIXED11, FMT_VAR11} frame_fmt_t;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage

// ---- rtl/uart_serial_port.sv ----
// Serial port: synchronous shift mode and three asynchronous frame modes.
// Assumes synchronous pin inputs and a master that never sends both strobes.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Format 00: half-duplex 8-bit shift on receive pin, clock on transmit pin, LSB first.
// - Format 01: full-duplex 10-bit frames, start, eight data, stop, timer baud.
// - Format 10: 11-bit frames with ninth bit at a fixed system clock fraction.
// - Format 11: same 11-bit frame, baud taken from a timer overflow.
// - 11-bit modes, gate clear: every complete frame sets receive-done and requests interrupt.
// - 11-bit modes, gate set: receive-done only when received ninth bit is one.
// - Reception starts only while receive-allow is one; clearing it stops an async frame, not a shift-mode byte.
// - 11-bit modes capture the received ninth bit into its flag.
// - Separate transmit-done and receive-done flags both raise the interrupt request.
// - Writing the data buffer loads the transmitter and starts the frame at once.
// - Shift mode rate is clock/12, or clock/4 with the doubler set.
// - Fixed 11-bit mode baud is clock/64, or clock/32 with the doubler set.
// - Each direction uses Timer2 when its select is set, else Timer1 overflow.
// - Timer1 baud is 2^doubler/16 of its clock over twice (256 - reload).
// - Timer1 clock is system clock/12, or undivided when its bit is set.
// - Timer2 baud is 1/16 of its clock over twice (65536 - reload).
// - Timer2 clock is system clock/12, or undivided when its bit is set.
module uart_serial_port (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    // Register port
    input wire uart_pkg::bus_req_t BUS_IN,
    output var logic [7:0] RD_DATA_OUT,
    // Serial pins
    input wire logic RX_IN,
    output var logic RX_OUT,
    output var logic RX_OE_N_OUT,
    output var logic TX_OUT,
    // Serial interrupt request
    output var logic IRQ_OUT
);

    typedef struct packed {
        logic [7:0] ctl;
        logic dbl;
        logic [7:0] sel;
        logic [7:0] t1_rel;
        logic [15:0] t2_rel;
        logic [7:0] rx_buf;
        logic [7:0] rd;
        logic [3:0] pre;
        logic [7:0] t1_cnt;
        logic [15:0] t2_cnt;
        logic t1_half;
        logic t2_half;
        logic [1:0] fix_cnt;
        logic [2:0] m0_div;
        uart_pkg::tx_state_t tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_bits;
        logic [3:0] tx_sub;
        uart_pkg::rx_state_t rx_st;
        logic rx_prev;
        logic [8:0] rx_sh;
        logic [3:0] rx_bits;
        logic [3:0] rx_sub;
        logic m0_busy;
        logic m0_rx;
        logic m0_clk;
        logic m0_ph;
        logic [2:0] m0_cnt;
        logic [7:0] m0_sh;
        logic txd;
        logic rxo;
        logic rx_oe_n;
        logic irq;
    } state_t;

    state_t q;
    state_t d;
    uart_pkg::frame_fmt_t fmt;
    logic eleven;
    logic pre_tick;
    logic t1_en;
    logic t1_ovf;
    logic t1_tick;
    logic t2_en;
    logic t2_ovf;
    logic t2_tick;
    logic fix_tick;
    logic m0_tick;
    logic tx_tick;
    logic rx_tick;
    logic ti_set;
    logic ri_set;
    logic rb8_set;
    logic rx_done;
    logic wr_ctl;
    logic [3:0] nbits;
    logic [3:0] tx_len;
    logic [7:0] rx_data;
    logic [7:0] m0_next;

    // Pick the baud tick of one direction
    function automatic logic pick_tick(input logic use_t2, input logic t2, input logic t1);
        pick_tick = use_t2 ? t2 : t1;
    endfunction

    always_comb
    begin
        d = q;
        fmt = uart_pkg::frame_fmt_t'(q.ctl[uart_pkg::CTL_FMT_HI:uart_pkg::CTL_FMT_LO]);
        eleven = (fmt == uart_pkg::FMT_FIXED11) || (fmt == uart_pkg::FMT_VAR11);
        nbits = eleven ? 4'h9 : 4'h8;
        tx_len = eleven ? 4'ha : 4'h9;
        ti_set = 1'b0;
        ri_set = 1'b0;
        rb8_set = 1'b0;
        rx_done = 1'b0;
        rx_data = eleven ? q.rx_sh[7:0] : q.rx_sh[8:1];
        m0_next = {RX_IN, q.m0_sh[7:1]};
        wr_ctl = BUS_IN.wr && (BUS_IN.addr == uart_pkg::ADDR_CONTROL);

        // Shared divide-by-12 prescaler and timer clocks
        pre_tick = (q.pre == uart_pkg::PRESCALE_LAST);
        d.pre = pre_tick ? 4'h0 : q.pre + 4'h1;
        t1_en = q.sel[uart_pkg::SEL_T1_UNDIV] || pre_tick;
        t2_en = q.sel[uart_pkg::SEL_T2_UNDIV] || pre_tick;

        // Timer1 8-bit auto-reload, halved, times 2^doubler
        t1_ovf = t1_en && (q.t1_cnt == uart_pkg::T1_TOP);
        if (t1_en)
        begin
            d.t1_cnt = t1_ovf ? q.t1_rel : q.t1_cnt + 8'h01;
        end
        if (t1_ovf)
        begin
            d.t1_half = !q.t1_half;
        end
        t1_tick = t1_ovf && (q.dbl || q.t1_half);

        // Timer2 16-bit auto-reload, halved, doubler ignored
        t2_ovf = t2_en && (q.t2_cnt == uart_pkg::T2_TOP);
        if (t2_en)
        begin
            d.t2_cnt = t2_ovf ? q.t2_rel : q.t2_cnt + 16'h0001;
        end
        if (t2_ovf)
        begin
            d.t2_half = !q.t2_half;
        end
        t2_tick = t2_ovf && q.t2_half;

        // Fixed-rate oversample tick: clock/4 or clock/2
        fix_tick = (q.fix_cnt == (q.dbl ? uart_pkg::FIXED_FAST_LAST : uart_pkg::FIXED_SLOW_LAST));
        d.fix_cnt = fix_tick ? 2'h0 : q.fix_cnt + 2'h1;

        // Shift-mode half-period tick: clock/6 or clock/2
        m0_tick = (q.m0_div == (q.dbl ? uart_pkg::SYNC_HALF_FAST_LAST
                                      : uart_pkg::SYNC_HALF_SLOW_LAST));
        d.m0_div = m0_tick ? 3'h0 : q.m0_div + 3'h1;

        // Per-direction source
        tx_tick = (fmt == uart_pkg::FMT_FIXED11) ? fix_tick
                : pick_tick(q.sel[uart_pkg::SEL_T2_TX], t2_tick, t1_tick);
        rx_tick = (fmt == uart_pkg::FMT_FIXED11) ? fix_tick
                : pick_tick(q.sel[uart_pkg::SEL_T2_RX], t2_tick, t1_tick);

        // Asynchronous transmitter
        if ((q.tx_st == uart_pkg::TX_SEND) && tx_tick)
        begin
            d.tx_sub = q.tx_sub + 4'h1;
            if (q.tx_sub == uart_pkg::OVERSAMPLE_LAST)
            begin
                d.tx_sh = {1'b1, q.tx_sh[10:1]};
                d.tx_bits = q.tx_bits + 4'h1;
                if (q.tx_bits + 4'h1 == tx_len)
                begin
                    ti_set = 1'b1;
                end
                if (q.tx_bits == tx_len)
                begin
                    d.tx_st = uart_pkg::TX_IDLE;
                end
            end
        end

        // Asynchronous receiver
        d.rx_prev = RX_IN;
        if ((fmt == uart_pkg::FMT_SYNC) || !q.ctl[uart_pkg::CTL_REN])
        begin
            d.rx_st = uart_pkg::RX_IDLE;
        end
        else
        begin
            case (q.rx_st)
                uart_pkg::RX_IDLE:
                begin
                    if (q.rx_prev && !RX_IN)
                    begin
                        d.rx_st = uart_pkg::RX_START;
                        d.rx_sub = 4'h0;
                    end
                end
                uart_pkg::RX_START:
                begin
                    if (rx_tick)
                    begin
                        d.rx_sub = q.rx_sub + 4'h1;
                        if (q.rx_sub == uart_pkg::SAMPLE_MID)
                        begin
                            d.rx_st = RX_IN ? uart_pkg::RX_IDLE : uart_pkg::RX_BITS;
                            d.rx_sub = 4'h0;
                            d.rx_bits = 4'h0;
                        end
                    end
                end
                default:
                begin
                    if (rx_tick)
                    begin
                        d.rx_sub = q.rx_sub + 4'h1;
                        if (q.rx_sub == uart_pkg::OVERSAMPLE_LAST)
                        begin
                            if (q.rx_bits != nbits)
                            begin
                                d.rx_sh = {RX_IN, q.rx_sh[8:1]};
                                d.rx_bits = q.rx_bits + 4'h1;
                            end
                            else
                            begin
                                rx_done = 1'b1;
                                d.rx_st = uart_pkg::RX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
        if (rx_done)
        begin
            if (eleven)
            begin
                rb8_set = 1'b1;
            end
            if (!eleven || !q.ctl[uart_pkg::CTL_GATE] || q.rx_sh[8])
            begin
                d.rx_buf = rx_data;
                ri_set = 1'b1;
            end
        end

        // Synchronous shift engine
        if (fmt != uart_pkg::FMT_SYNC)
        begin
            d.m0_busy = 1'b0;
            d.rx_oe_n = 1'b1;
            d.m0_clk = 1'b1;
        end
        else if (q.m0_busy && m0_tick)
        begin
            d.m0_ph = !q.m0_ph;
            d.m0_clk = q.m0_ph;
            if (q.m0_ph)
            begin
                d.m0_cnt = q.m0_cnt + 3'h1;
                d.m0_sh = q.m0_rx ? m0_next : {1'b1, q.m0_sh[7:1]};
                d.rxo = q.m0_sh[1];
                if (q.m0_cnt == 3'h7)
                begin
                    d.m0_busy = 1'b0;
                    d.rx_oe_n = 1'b1;
                    d.rxo = 1'b1;
                    if (q.m0_rx)
                    begin
                        d.rx_buf = m0_next;
                        ri_set = 1'b1;
                    end
                    else
                    begin
                        ti_set = 1'b1;
                    end
                end
            end
        end
        else if (!q.m0_busy && q.ctl[uart_pkg::CTL_REN] && !q.ctl[uart_pkg::CTL_RI])
        begin
            d.m0_busy = 1'b1;
            d.m0_rx = 1'b1;
            d.m0_ph = 1'b0;
            d.m0_cnt = 3'h0;
            d.m0_clk = 1'b1;
        end

        // Register writes
        if (BUS_IN.wr)
        begin
            if (BUS_IN.addr == uart_pkg::ADDR_CONTROL)
            begin
                d.ctl = BUS_IN.wdata;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_DATA)
            begin
                if (fmt == uart_pkg::FMT_SYNC)
                begin
                    d.m0_busy = 1'b1;
                    d.m0_rx = 1'b0;
                    d.m0_ph = 1'b0;
                    d.m0_cnt = 3'h0;
                    d.m0_clk = 1'b1;
                    d.m0_sh = BUS_IN.wdata;
                    d.rxo = BUS_IN.wdata[0];
                    d.rx_oe_n = 1'b0;
                end
                else
                begin
                    d.tx_st = uart_pkg::TX_SEND;
                    d.tx_sub = 4'h0;
                    d.tx_bits = 4'h0;
                    d.tx_sh = eleven ? {1'b1, q.ctl[uart_pkg::CTL_TB8], BUS_IN.wdata, 1'b0}
                                     : {2'b11, BUS_IN.wdata, 1'b0};
                end
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_POWER)
            begin
                d.dbl = BUS_IN.wdata[uart_pkg::PWR_DOUBLER];
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_BAUD_SEL)
            begin
                d.sel = BUS_IN.wdata;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_T1_RELOAD)
            begin
                d.t1_rel = BUS_IN.wdata;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_T2_RELOAD_LO)
            begin
                d.t2_rel[7:0] = BUS_IN.wdata;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_T2_RELOAD_HI)
            begin
                d.t2_rel[15:8] = BUS_IN.wdata;
            end
        end

        // Register reads, data valid in the next cycle only
        d.rd = 8'h00;
        if (BUS_IN.rd)
        begin
            if (BUS_IN.addr == uart_pkg::ADDR_CONTROL)
            begin
                d.rd = q.ctl;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_DATA)
            begin
                d.rd = q.rx_buf;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_BAUD_SEL)
            begin
                d.rd = q.sel;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_T1_RELOAD)
            begin
                d.rd = q.t1_rel;
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_T2_RELOAD_LO)
            begin
                d.rd = q.t2_rel[7:0];
            end
            else if (BUS_IN.addr == uart_pkg::ADDR_T2_RELOAD_HI)
            begin
                d.rd = q.t2_rel[15:8];
            end
        end

        // Hardware sets win over software writes
        if (ti_set)
        begin
            d.ctl[uart_pkg::CTL_TI] = 1'b1;
        end
        if (ri_set)
        begin
            d.ctl[uart_pkg::CTL_RI] = 1'b1;
        end
        if (rb8_set)
        begin
            d.ctl[uart_pkg::CTL_RB8] = q.rx_sh[8];
        end
        d.irq = d.ctl[uart_pkg::CTL_TI] || d.ctl[uart_pkg::CTL_RI];
        d.txd = (fmt == uart_pkg::FMT_SYNC) ? d.m0_clk : d.tx_sh[0];
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            q <= '0;
            q.ctl <= uart_pkg::CONTROL_RESET;
            q.rx_buf <= uart_pkg::DATA_RESET;
            q.sel <= uart_pkg::BAUD_SEL_RESET;
            q.t1_rel <= uart_pkg::T1_RELOAD_RESET;
            q.t2_rel <= uart_pkg::T2_RELOAD_RESET;
            q.tx_st <= uart_pkg::TX_IDLE;
            q.rx_st <= uart_pkg::RX_IDLE;
            q.tx_sh <= uart_pkg::TX_IDLE_LINE;
            q.rx_prev <= 1'b1;
            q.m0_clk <= 1'b1;
            q.txd <= 1'b1;
            q.rxo <= 1'b1;
            q.rx_oe_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign RD_DATA_OUT = q.rd;
    assign RX_OUT = q.rxo;
    assign RX_OE_N_OUT = q.rx_oe_n;
    assign TX_OUT = q.txd;
    assign IRQ_OUT = q.irq;

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // Gap checked only while the doubler stays clear
    sequence s_sync_slow_gap;
        (!m0_tick || q.dbl) [*5] ##1 (m0_tick || q.dbl);
    endsequence

    sequence s_fixed_slow_gap;
        (!fix_tick || q.dbl) [*3] ##1 (fix_tick || q.dbl);
    endsequence

    a_tx_start_bit: assert property (
        (BUS_IN.wr && BUS_IN.addr == uart_pkg::ADDR_DATA && fmt != uart_pkg::FMT_SYNC)
        |=> (TX_OUT == 1'b0) && (q.tx_st == uart_pkg::TX_SEND))
        else $error("Data write did not start the frame");

    a_read_latch: assert property (
        (BUS_IN.rd && BUS_IN.addr == uart_pkg::ADDR_DATA) |=> RD_DATA_OUT == $past(q.rx_buf))
        else $error("Data read did not return the receive latch");

    a_ren_inhibit: assert property (
        (q.rx_st == uart_pkg::RX_IDLE && !q.ctl[uart_pkg::CTL_REN]) |=> q.rx_st == uart_pkg::RX_IDLE)
        else $error("Receiver left idle while reception is off");

    a_gate_block: assert property (
        (rx_done && eleven && q.ctl[uart_pkg::CTL_GATE] && !q.rx_sh[8]
         && !q.ctl[uart_pkg::CTL_RI] && !wr_ctl) |=> !q.ctl[uart_pkg::CTL_RI])
        else $error("Receive-done set with ninth bit zero under gate");

    a_gate_open: assert property (
        (rx_done && eleven && !q.ctl[uart_pkg::CTL_GATE]) |=> q.ctl[uart_pkg::CTL_RI] && IRQ_OUT)
        else $error("Complete frame did not raise receive-done");

    a_ninth_capture: assert property (
        (rx_done && eleven) |=> q.ctl[uart_pkg::CTL_RB8] == $past(q.rx_sh[8]))
        else $error("Received ninth bit not captured");

    a_flag_sticky: assert property (
        (q.ctl[uart_pkg::CTL_TI] && !wr_ctl) |=> q.ctl[uart_pkg::CTL_TI])
        else $error("Transmit-done cleared without a write");

    a_sync_rate: assert property (
        (m0_tick && !q.dbl) |=> s_sync_slow_gap)
        else $error("Shift half-period not six clocks");

    a_fixed_rate: assert property (
        (fix_tick && !q.dbl) |=> s_fixed_slow_gap)
        else $error("Fixed oversample period not four clocks");

endmodule

`default_nettype wire

// ---- tb/remote_serial_model.sv ----
// Remote serial device: sends frames onto the receive pin, decodes frames from the transmit pin.
// Assumes the bench sets bit length in clocks and frame bits before each frame; 0 bits idles it.
`timescale 1ns/100ps
`default_nettype none
module remote_serial_model (
    // Clock
    input wire logic clk_in,
    // Line from the port and frame shape
    input wire logic line_in,
    input wire logic [3:0] nbits_in,
    input wire logic [7:0] bit_clks_in,
    // Line to the port and decoded frame
    output logic line_out,
    output logic seen_out,
    output logic [9:0] bits_out
);
    // Decode: start on a falling edge, sample each bit at its centre, stop bit last
    initial
    begin
        line_out = 1'b1;
        seen_out = 1'b0;
        bits_out = 10'h000;
        forever
        begin
            @(negedge line_in);
            if (nbits_in != 4'h0)
            begin
                bits_out <= 10'h000;
                repeat (bit_clks_in / 2) @(posedge clk_in);
                for (int i = 0; i <= nbits_in; i++)
                begin
                    repeat (bit_clks_in) @(posedge clk_in);
                    bits_out[i] <= line_in;
                end
                seen_out <= 1'b1;
                @(posedge clk_in);
                seen_out <= 1'b0;
            end
        end
    end

    // Send start, data, ninth and stop bits, least significant first
    task automatic send(input logic [9:0] bits);
        line_out <= 1'b0;
        repeat (bit_clks_in) @(posedge clk_in);
        for (int i = 0; i <= nbits_in; i++)
        begin
            line_out <= bits[i];
            repeat (bit_clks_in) @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask

    // Shift-mode source: each bit stands before the port's rising shift clock
    task automatic shift_out(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
        begin
            line_out <= v[i];
            @(posedge line_in);
            @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb/uart_serial_port_tb.sv ----
// Testbench of the serial port with a remote device model on its pins.
// Assumes the package constants and register map of the design.
`timescale 1ns/100ps
`default_nettype none
module uart_serial_port_tb;
    logic clk, rst_n, rx_pin, rx_drv, rx_oe_n, tx_line, irq, line, seen, rd_d, prev, oe_seen;
    uart_pkg::bus_req_t bus;
    logic [7:0] rd_data, d, got;
    logic [9:0] bits;
    logic [3:0] nbits;
    logic [7:0] bclk;
    logic [31:0] seed;
    logic [7:0] rd_q[$];
    logic [9:0] fr_q[$];
    int fail_count, compares, cycles, n, first, last;

    assign rx_pin = rx_oe_n ? line : rx_drv;

    uart_serial_port uart_serial_port_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .BUS_IN(bus),
        .RD_DATA_OUT(rd_data), .RX_IN(rx_pin), .RX_OUT(rx_drv), .RX_OE_N_OUT(rx_oe_n),
        .TX_OUT(tx_line), .IRQ_OUT(irq));
    remote_serial_model remote_serial_model_i (.clk_in(clk), .line_in(tx_line),
        .nbits_in(nbits), .bit_clks_in(bclk), .line_out(line), .seen_out(seen),
        .bits_out(bits));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [9:0] got_v, input logic [9:0] exp_v);
        compares++;
        if (got_v !== exp_v)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask

    task automatic wait_frames();
        for (int i = 0; i < 800 && fr_q.size() != 0; i++) @(posedge clk);
        check(10'(fr_q.size()), 10'h000);
    endtask

    // Watcher: read data the cycle after a read strobe, decoded frames when seen
    always @(posedge clk)
    begin
        cycles++;
        if (rd_d)
            check({2'h0, rd_data}, {2'h0, rd_q.pop_front()});
        if (seen)
            check(bits, fr_q.pop_front());
        rd_d <= bus.rd;
        if (cycles == 6000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        bus = '0;
        seed = 32'he641e677;
        nbits = 4'h0;
        bclk = 8'h10;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(uart_pkg::ADDR_CONTROL, uart_pkg::CONTROL_RESET);
        rd(uart_pkg::ADDR_DATA, uart_pkg::DATA_RESET);
        rd(uart_pkg::ADDR_POWER, 8'h00);
        rd(8'h55, 8'h00);
        check({9'h000, irq}, 10'h000);
        // Timer1 undivided, reload 0xff, doubler set: 16 clocks a bit
        wr(uart_pkg::ADDR_POWER, 8'h80);
        wr(uart_pkg::ADDR_BAUD_SEL, 8'h01);
        wr(uart_pkg::ADDR_T1_RELOAD, 8'hff);
        // Let Timer1 reach its first overflow so the reload takes effect
        repeat (256) @(posedge clk);
        rd(uart_pkg::ADDR_BAUD_SEL, 8'h01);
        wr(uart_pkg::ADDR_CONTROL, 8'hf0);
        nbits = 4'h9;
        remote_serial_model_i.send({2'h2, rnd()});
        rd(uart_pkg::ADDR_CONTROL, 8'hf0);
        rd(uart_pkg::ADDR_DATA, 8'h00);
        d = rnd();
        remote_serial_model_i.send({2'h3, d});
        rd(uart_pkg::ADDR_CONTROL, 8'hf5);
        rd(uart_pkg::ADDR_DATA, d);
        check({9'h000, irq}, 10'h001);
        wr(uart_pkg::ADDR_CONTROL, 8'hd0);
        d = rnd();
        remote_serial_model_i.send({2'h2, d});
        rd(uart_pkg::ADDR_CONTROL, 8'hd1);
        rd(uart_pkg::ADDR_DATA, d);
        wr(uart_pkg::ADDR_CONTROL, 8'hc0);
        remote_serial_model_i.send({2'h3, rnd()});
        rd(uart_pkg::ADDR_CONTROL, 8'hc0);
        rd(uart_pkg::ADDR_DATA, d);
        // Format 01 both ways at once
        wr(uart_pkg::ADDR_CONTROL, 8'h50);
        nbits = 4'h8;
        d = rnd();
        fr_q.push_back({2'h1, d});
        wr(uart_pkg::ADDR_DATA, d);
        d = rnd();
        remote_serial_model_i.send({2'h1, d});
        wait_frames();
        rd(uart_pkg::ADDR_DATA, d);
        // Format 10, doubler set: 32 clocks a bit, ninth bit one
        wr(uart_pkg::ADDR_CONTROL, 8'h88);
        bclk = 8'h20;
        nbits = 4'h9;
        d = rnd();
        fr_q.push_back({2'h3, d});
        wr(uart_pkg::ADDR_DATA, d);
        wait_frames();
        rd(uart_pkg::ADDR_CONTROL, 8'h8a);
        // Shift mode, doubler set: half period of 2 clocks
        wr(uart_pkg::ADDR_CONTROL, 8'h00);
        nbits = 4'h0;
        d = rnd();
        wr(uart_pkg::ADDR_DATA, d);
        n = 0;
        prev = tx_line;
        for (int c = 0; c < 200 && n < 8; c++)
        begin
            @(posedge clk);
            if (!tx_line && prev)
            begin
                got[n] = rx_drv;
                if (n == 0)
                    oe_seen = rx_oe_n;
                if (n == 0)
                    first = c;
                last = c;
                n++;
            end
            prev = tx_line;
        end
        check({2'h0, got}, {2'h0, d});
        check({9'h000, oe_seen}, 10'h000);
        check(10'(last - first), 10'h01c);
        for (int i = 0; i < 50 && !irq; i++) @(posedge clk);
        rd(uart_pkg::ADDR_CONTROL, 8'h02);
        // Shift mode receive from the remote device
        wr(uart_pkg::ADDR_CONTROL, 8'h10);
        d = rnd();
        remote_serial_model_i.shift_out(d);
        rd(uart_pkg::ADDR_CONTROL, 8'h11);
        rd(uart_pkg::ADDR_DATA, d);
        tally_and_finish();
    end
endmodule
`default_nettype wire
